// *** rtl/hub_desc_defines.vh ***
`ifndef HUB_DESC_DEFINES_VH
`define HUB_DESC_DEFINES_VH

// register indices; byte address on apb is index times four
`define IDX_CURRENT       10'h00F
`define IDX_POWER_DELAY   10'h010
`define IDX_LANG_UPPER    10'h011
`define IDX_LANG_LOWER    10'h012
`define IDX_MAKER_LEN     10'h013
`define IDX_ITEM_LEN      10'h014
`define IDX_UNIT_LEN      10'h015
`define IDX_STR_FIRST     10'h016
`define IDX_STR_LAST      10'h053
`define IDX_STATUS        10'h0E0

// apb address layout
`define ADDR_W            12
`define IDX_LSB           2

// reset values
`define CURRENT_RESET     8'h32
`define BYTE_RESET        8'h00

// string limits
`define MAX_STR_CHARS     8'h1F
`define STR_BYTES         62
`define STR_OFF_W         6

// status bit positions
`define STAT_PENDING      0
`define STAT_GOOD         1
`define STAT_STR_BUSY     2

// timing: one delay unit is 2 ms, clock period 20 ns
`define POWER_UNIT_NS     2000000
`define CLK_PERIOD_NS     20
`define POWER_UNIT_CYCLES (`POWER_UNIT_NS / `CLK_PERIOD_NS)
`endif

// *** rtl/power_on_timer.v ***
`timescale 1ns/100ps
`include "hub_desc_defines.vh"
module power_on_timer #(
  parameter UNIT_CYCLES = `POWER_UNIT_CYCLES,
  parameter CNT_W       = 17
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       start,
  input  wire [7:0] delay_units,
  output reg        pending_reg,
  output reg        good_reg
);
  // the count is cut to the counter width on purpose; UNIT_CYCLES must fit in CNT_W bits
  localparam integer     LAST_CYC_INT = UNIT_CYCLES - 1;
  localparam [CNT_W-1:0] LAST_CYC     = LAST_CYC_INT[CNT_W-1:0];

  reg [CNT_W-1:0] cyc_reg;
  reg [7:0]       units_reg;

  // counts whole delay units; a new start restarts the sequence
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg     <= {CNT_W{1'b0}};
      units_reg   <= 8'h00;
      pending_reg <= 1'b0;
      good_reg    <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        cyc_reg     <= {CNT_W{1'b0}};
        units_reg   <= delay_units;
        pending_reg <= 1'b1;
        good_reg    <= 1'b0;
      end else if (pending_reg) begin
        if (units_reg == 8'h00) begin
          pending_reg <= 1'b0;
          good_reg    <= 1'b1;
        end else if (cyc_reg == LAST_CYC) begin
          cyc_reg   <= {CNT_W{1'b0}};
          units_reg <= units_reg - 8'h01;
        end else begin
          cyc_reg <= cyc_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // power_on_timer

// *** rtl/string_streamer.v ***
`timescale 1ns/100ps
`include "hub_desc_defines.vh"
module string_streamer (
  input  wire                  clk,
  input  wire                  rst_n,
  input  wire                  clk_en,
  input  wire                  start,
  input  wire [4:0]            char_count,
  input  wire [7:0]            rd_data,
  input  wire                  out_ready,
  output wire [`STR_OFF_W-1:0] rd_off,
  output reg  [7:0]            byte_reg,
  output reg                   valid_reg,
  output reg                   last_reg,
  output reg                   busy_reg
);
  reg [`STR_OFF_W-1:0] off_reg;
  reg [`STR_OFF_W-1:0] total_reg;

  assign rd_off = off_reg;

  // bytes leave in ascending address order, low byte of each character first
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      off_reg   <= {`STR_OFF_W{1'b0}};
      total_reg <= {`STR_OFF_W{1'b0}};
      byte_reg  <= 8'h00;
      valid_reg <= 1'b0;
      last_reg  <= 1'b0;
      busy_reg  <= 1'b0;
    end else if (clk_en) begin
      if (!busy_reg) begin
        if (start && char_count != 5'h00) begin
          off_reg   <= {`STR_OFF_W{1'b0}};
          total_reg <= {char_count, 1'b0};
          busy_reg  <= 1'b1;
        end
      end else if (!valid_reg || out_ready) begin
        if (valid_reg && last_reg) begin
          // final byte taken: stream ends
          valid_reg <= 1'b0;
          last_reg  <= 1'b0;
          busy_reg  <= 1'b0;
        end else begin
          byte_reg  <= rd_data;
          valid_reg <= 1'b1;
          last_reg  <= (off_reg == total_reg - 6'h01);
          off_reg   <= off_reg + 6'h01;
        end
      end
    end
  end
endmodule // string_streamer

// *** rtl/hub_descriptor_config_regs.v ***
`timescale 1ns/100ps
`include "hub_desc_defines.vh"
module hub_descriptor_config_regs #(
  parameter POWER_UNIT_CYCLES = `POWER_UNIT_CYCLES,
  parameter POWER_CNT_W       = 17
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              clk_en,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [`ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              port_power_start,
  output wire              port_power_pending,
  output wire              port_power_good,
  input  wire              maker_str_req,
  input  wire              maker_str_ready,
  output wire [7:0]        maker_str_byte,
  output wire              maker_str_valid,
  output wire              maker_str_last,
  output wire              maker_str_busy,
  output reg  [8:0]        hub_ctrl_current_ma,
  output reg  [15:0]       language_id,
  output reg  [7:0]        hub_ctrl_current_bus_powered_reg,
  output reg  [7:0]        port_power_on_delay_reg,
  output reg  [7:0]        maker_string_length_reg,
  output reg  [7:0]        item_string_length_reg,
  output reg  [7:0]        unit_number_string_length_reg
);
  reg  [7:0]            language_id_upper_reg;
  reg  [7:0]            language_id_lower_reg;
  // manufacturer string bytes, one per word index from 16h
  reg  [7:0]            maker_string_storage [0:`STR_BYTES-1];

  wire [9:0]            idx;
  wire [9:0]            str_diff;
  wire [`STR_OFF_W-1:0] str_off;
  wire                  access;
  wire                  in_range;
  wire                  is_status;
  wire                  mapped;
  wire                  do_write;
  wire [7:0]            wbyte;
  wire [7:0]            wlen;
  wire [`STR_OFF_W-1:0] stream_off;
  wire [7:0]            stream_data;
  reg  [31:0]           rd_word;
  integer               i;

  // word index from byte address; low address bits do not select a byte
  assign idx       = paddr[`ADDR_W-1:`IDX_LSB];
  assign str_diff  = idx - `IDX_STR_FIRST;
  assign str_off   = str_diff[`STR_OFF_W-1:0];
  assign access    = psel & penable;
  assign in_range  = (idx >= `IDX_CURRENT) && (idx <= `IDX_STR_LAST);
  assign is_status = (idx == `IDX_STATUS);
  assign mapped    = in_range | is_status;
  assign wbyte     = pwdata[7:0];

  // write lands only on the edge where the master sees pready high
  assign do_write  = access & pready & pwrite & in_range;

  // lengths saturate so no string can be announced longer than 31 characters
  assign wlen = (wbyte > `MAX_STR_CHARS) ? `MAX_STR_CHARS : wbyte;

  // read data mux; narrow registers sit in the low byte
  always @* begin
    rd_word = 32'h0000_0000;
    if (idx >= `IDX_STR_FIRST && idx <= `IDX_STR_LAST) begin
      rd_word[7:0] = maker_string_storage[str_off];
    end else begin
      case (idx)
        `IDX_CURRENT:     rd_word[7:0] = hub_ctrl_current_bus_powered_reg;
        `IDX_POWER_DELAY: rd_word[7:0] = port_power_on_delay_reg;
        `IDX_LANG_UPPER:  rd_word[7:0] = language_id_upper_reg;
        `IDX_LANG_LOWER:  rd_word[7:0] = language_id_lower_reg;
        `IDX_MAKER_LEN:   rd_word[7:0] = maker_string_length_reg;
        `IDX_ITEM_LEN:    rd_word[7:0] = item_string_length_reg;
        `IDX_UNIT_LEN:    rd_word[7:0] = unit_number_string_length_reg;
        `IDX_STATUS: begin
          rd_word[`STAT_PENDING]  = port_power_pending;
          rd_word[`STAT_GOOD]     = port_power_good;
          rd_word[`STAT_STR_BUSY] = maker_str_busy;
        end
        default:          rd_word = 32'h0000_0000;
      endcase
    end
  end

  // apb answer: one wait state, pready then drops for the next request
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (access && !pready) begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : rd_word;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // configuration registers; status index is read only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hub_ctrl_current_bus_powered_reg <= `CURRENT_RESET;
      port_power_on_delay_reg          <= `BYTE_RESET;
      language_id_upper_reg            <= `BYTE_RESET;
      language_id_lower_reg            <= `BYTE_RESET;
      maker_string_length_reg          <= `BYTE_RESET;
      item_string_length_reg           <= `BYTE_RESET;
      unit_number_string_length_reg    <= `BYTE_RESET;
    end else if (clk_en && do_write) begin
      case (idx)
        `IDX_CURRENT:     hub_ctrl_current_bus_powered_reg <= wbyte;
        `IDX_POWER_DELAY: port_power_on_delay_reg          <= wbyte;
        `IDX_LANG_UPPER:  language_id_upper_reg            <= wbyte;
        `IDX_LANG_LOWER:  language_id_lower_reg            <= wbyte;
        `IDX_MAKER_LEN:   maker_string_length_reg          <= wlen;
        `IDX_ITEM_LEN:    item_string_length_reg           <= wlen;
        `IDX_UNIT_LEN:    unit_number_string_length_reg    <= wlen;
        default:          port_power_on_delay_reg          <= port_power_on_delay_reg;
      endcase
    end
  end

  // string storage cleared at reset so reads never return unknowns
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `STR_BYTES; i = i + 1) begin
        maker_string_storage[i] <= `BYTE_RESET;
      end
    end else if (clk_en && do_write && idx >= `IDX_STR_FIRST) begin
      maker_string_storage[str_off] <= wbyte;
    end
  end

  // derived descriptor values, registered so outputs come from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hub_ctrl_current_ma <= 9'h000;
      language_id         <= 16'h0000;
    end else if (clk_en) begin
      hub_ctrl_current_ma <= {hub_ctrl_current_bus_powered_reg, 1'b0};
      language_id         <= {language_id_upper_reg, language_id_lower_reg};
    end
  end

  // port power-on delay, counted in whole 2 ms units
  power_on_timer #(
    .UNIT_CYCLES (POWER_UNIT_CYCLES),
    .CNT_W       (POWER_CNT_W)
  ) u_power_timer (
    .clk         (pclk),
    .rst_n       (presetn),
    .clk_en      (clk_en),
    .start       (port_power_start),
    .delay_units (port_power_on_delay_reg),
    .pending_reg (port_power_pending),
    .good_reg    (port_power_good)
  );

  // the streamer reads storage through its own port, in parallel with apb
  assign stream_data = maker_string_storage[stream_off];

  // length is sampled at the request; a later length write does not cut a running stream
  string_streamer u_maker_stream (
    .clk        (pclk),
    .rst_n      (presetn),
    .clk_en     (clk_en),
    .start      (maker_str_req),
    .char_count (maker_string_length_reg[4:0]),
    .rd_data    (stream_data),
    .out_ready  (maker_str_ready),
    .rd_off     (stream_off),
    .byte_reg   (maker_str_byte),
    .valid_reg  (maker_str_valid),
    .last_reg   (maker_str_last),
    .busy_reg   (maker_str_busy)
  );
endmodule // hub_descriptor_config_regs

// *** dv/hub_desc_assertions.sv ***
`timescale 1ns/100ps
module hub_desc_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire [7:0]  hub_ctrl_current_bus_powered_reg,
  input wire [8:0]  hub_ctrl_current_ma,
  input wire [15:0] language_id,
  input wire [7:0]  maker_str_byte,
  input wire        maker_str_valid,
  input wire        maker_str_ready,
  input wire        maker_str_last,
  input wire        maker_str_busy,
  input wire [7:0]  maker_string_length_reg
);
  // decoded view of the apb request
  wire [9:0] idx  = paddr[11:2];
  wire       bad  = (idx < 10'h00F) || (idx > 10'h053 && idx != 10'h0E0);
  wire       done = psel && penable && pready;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // the mA view trails the byte by one enabled cycle, so skip the edge right after reset
  a_cur_ma_scale: assert property ($past(presetn) && $past(clk_en) |->
    hub_ctrl_current_ma == {$past(hub_ctrl_current_bus_powered_reg), 1'b0}) else $error("mA view wrong");
  a_cur_reset: assert property ($rose(presetn) |-> hub_ctrl_current_bus_powered_reg == 8'h32)
    else $error("current byte reset value wrong");
  a_lang_upper: assert property (done && clk_en && pwrite && idx == 10'h011 ##1 clk_en |=>
    language_id[15:8] == $past(pwdata[7:0], 2)) else $error("language id upper byte wrong");
  a_err_flag: assert property (done |-> pslverr == bad) else $error("error response wrong");
  a_one_wait: assert property (psel && penable && !pready && clk_en |=> pready) else $error("apb answer late");
  a_hold_byte: assert property (maker_str_valid && !maker_str_ready |=>
    maker_str_valid && $stable(maker_str_byte) && $stable(maker_str_last)) else $error("byte not held");
  a_len_cap: assert property (maker_string_length_reg <= 8'h1F) else $error("length above 31");
  a_stream_end: assert property (maker_str_valid && maker_str_ready && maker_str_last && clk_en |=>
    !maker_str_valid && !maker_str_busy) else $error("stream ran past its length");

  c_err: cover property (done && bad);
  c_stall: cover property (maker_str_valid && !maker_str_ready);
  c_end: cover property (maker_str_valid && maker_str_ready && maker_str_last);
endmodule // hub_desc_assertions

// *** dv/string_host_model.sv ***
`timescale 1ns/100ps
module string_host_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] maker_str_byte,
  input  wire       maker_str_valid,
  input  wire       maker_str_last,
  output reg        maker_str_ready
);
  logic [7:0] got[$];
  int         last_at;
  logic [2:0] ph;

  // host keeps bytes in arrival order; a fixed pattern makes it stall on some cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph              <= 3'h0;
      maker_str_ready <= 1'b0;
    end else begin
      ph              <= ph + 3'h1;
      maker_str_ready <= ph[0] | ph[2];
      if (maker_str_valid && maker_str_ready) begin
        got.push_back(maker_str_byte);
        if (maker_str_last)
          last_at = got.size();
      end
    end
  end
endmodule // string_host_model

// *** dv/hub_descriptor_config_regs_tb.sv ***
`timescale 1ns/100ps
bind hub_descriptor_config_regs hub_desc_assertions u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .hub_ctrl_current_bus_powered_reg, .hub_ctrl_current_ma, .language_id,
  .maker_str_byte, .maker_str_valid, .maker_str_ready, .maker_str_last, .maker_str_busy, .maker_string_length_reg);
module hub_descriptor_config_regs_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        port_power_start = 1'b0;
  logic        maker_str_req = 1'b0;
  logic [31:0] prdata;
  logic [31:0] seed = 32'h45;
  logic        pready, pslverr, pend, good, s_rdy, s_vld, s_last, s_busy;
  logic [7:0]  s_byte;
  logic [7:0]  cur_q, dly_q, mlen_q, ilen_q, ulen_q;
  logic [8:0]  ma;
  logic [15:0] lang;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  // 50 MHz clock
  always #10 pclk = ~pclk;

  hub_descriptor_config_regs #(.POWER_UNIT_CYCLES(4)) DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .port_power_start, .port_power_pending(pend),
    .port_power_good(good), .maker_str_req, .maker_str_ready(s_rdy), .maker_str_byte(s_byte),
    .maker_str_valid(s_vld), .maker_str_last(s_last), .maker_str_busy(s_busy), .hub_ctrl_current_ma(ma),
    .language_id(lang), .hub_ctrl_current_bus_powered_reg(cur_q), .port_power_on_delay_reg(dly_q),
    .maker_string_length_reg(mlen_q), .item_string_length_reg(ilen_q), .unit_number_string_length_reg(ulen_q));
  string_host_model u_host (.pclk, .presetn, .maker_str_byte(s_byte), .maker_str_valid(s_vld),
    .maker_str_last(s_last), .maker_str_ready(s_rdy));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // lengths above 31 are stored as 31
  function automatic logic [31:0] clamp(input logic [7:0] v);
    return (v > 8'h1F) ? 32'h1F : {24'h0, v};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; the run timeout cuts a missing answer short
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] rd,
                     output logic er);
    logic [31:0] r;
    r = xs();
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= {r[31:8], d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // the whole run needs well under two thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    logic [31:0] rd;
    logic        er;
    logic [7:0]  v, u, mem[62];
    logic [7:0]  lens[4];
    logic [7:0]  lv[4];
    logic [9:0]  bad[3];
    lens = '{8'h01, 8'h1F, 8'h00, 8'h02};
    lv   = '{8'h1F, 8'h20, 8'hFF, 8'h05};
    bad  = '{10'h00E, 10'h054, 10'h3FF};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 10'h00F, 8'h00, rd, er);
    chk(rd, 32'h32);
    chk(32'(ma), 32'h64);
    v = 8'(xs());
    u = 8'(xs());
    apb(1'b1, 10'h00F, v, rd, er);
    apb(1'b1, 10'h011, v, rd, er);
    apb(1'b1, 10'h012, u, rd, er);
    @(posedge pclk);
    #1;
    chk(32'(ma), {23'h0, v, 1'b0});
    chk({16'h0, lang}, {16'h0, v, u});
    chk({24'h0, cur_q}, {24'h0, v});
    for (int i = 19; i < 22; i++)
      foreach (lv[k]) begin
        apb(1'b1, i[9:0], lv[k], rd, er);
        apb(1'b0, i[9:0], 8'h00, rd, er);
        chk(rd, clamp(lv[k]));
        chk({24'h0, (i == 19) ? mlen_q : (i == 20) ? ilen_q : ulen_q}, clamp(lv[k]));
      end
    // unmapped places answer with an error and zero data
    foreach (bad[k]) begin
      apb(k[0], bad[k], 8'hA5, rd, er);
      chk({rd[30:0], er}, 32'h1);
    end
    // whole storage filled at random, then only length characters stream out
    foreach (lens[k]) begin
      for (int j = 0; j < 62; j++) begin
        mem[j] = 8'(xs());
        apb(1'b1, 10'h016 + j[9:0], mem[j], rd, er);
      end
      apb(1'b1, 10'h013, lens[k], rd, er);
      u_host.got.delete();
      u_host.last_at = 0;
      maker_str_req <= 1'b1;
      @(posedge pclk);
      maker_str_req <= 1'b0;
      repeat (3) @(posedge pclk);
      while (s_busy === 1'b1) @(posedge pclk);
      chk(32'(u_host.got.size()), 32'(2 * lens[k]));
      chk(32'(u_host.last_at), 32'(2 * lens[k]));
      foreach (u_host.got[j]) chk(32'(u_host.got[j]), 32'(mem[j]));
    end
    // three units of four cycles: good comes 13 edges after the start edge
    apb(1'b1, 10'h010, 8'h03, rd, er);
    port_power_start <= 1'b1;
    @(posedge pclk);
    port_power_start <= 1'b0;
    @(posedge pclk);
    #1;
    chk({30'h0, good, pend}, 32'h1);
    repeat (11) @(posedge pclk);
    #1;
    chk({30'h0, good, pend}, 32'h1);
    @(posedge pclk);
    #1;
    chk({30'h0, good, pend}, 32'h2);
    apb(1'b0, 10'h0E0, 8'h00, rd, er);
    chk(rd, 32'h2);
    apb(1'b0, 10'h010, 8'h00, rd, er);
    chk(rd, 32'h3);
    chk({24'h0, dly_q}, 32'h3);
    // with the enable low a start pulse must be ignored and the timer must hold its state
    clk_en           <= 1'b0;
    port_power_start <= 1'b1;
    repeat (3) @(posedge pclk);
    port_power_start <= 1'b0;
    clk_en           <= 1'b1;
    @(posedge pclk);
    #1;
    chk({30'h0, good, pend}, 32'h2);
    results();
  end
endmodule // hub_descriptor_config_regs_tb
